// ---- omw_ctrl.sv ----
// Operating-mode controller: power-down, idle, active and connected modes
// Assumes one 25 MHz clock; all power, wake and activity pins are asynchronous and synchronised here
//
// Functional notes
// - No switch-on while main supply absent
// - Power-off wakes on pin, reset, alarm
// - Shutdown command enters power-off, interfaces closed
// - Idle uses slow reference, interfaces disabled
// - Active uses fast reference, interfaces enabled
// - Power saving off after start, auto idle
// - Flow control on: clear-to-send tracks readiness
// - Flow control off: clear-to-send always on
// - Registered: periodic wake for paging blocks
// - Unregistered: periodic wake to check activity
// - Incoming call or alarm wakes idle
// - UART receive data wakes idle
// - Setting 2: request-to-send on wakes idle
// - Bus supply sense wakes idle
// - USB remote wakeup wakes idle
// - Host ready indication wakes idle
// - Call end returns to prior mode
// - Interface supply only when on, unreset
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "omw_consts.svh"
module omw_ctrl
  import omw_pkg::*;
#(
  parameter int unsigned POLL_CYC  = `OMW_POLL_CYC,
  parameter int unsigned AWAKE_CYC = `OMW_AWAKE_CYC,
  parameter int unsigned HOLD_CYC  = `OMW_IDLE_HOLD_CYC
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Power and switch-on pins
  input  wire logic        supply_ok,
  input  wire logic        power_on_request_n,
  input  wire logic        ext_reset_n,
  input  wire logic        rtc_alarm,
  // Wake sources and activity
  input  wire logic        uart_rxd,
  input  wire logic        rts_on,
  input  wire logic        usb_bus_sense,
  input  wire logic        usb_remote_wakeup,
  input  wire logic        host_ready_indication,
  input  wire logic        call_incoming,
  input  wire logic        call_active,
  input  wire logic        busy,
  // Mode outputs
  output logic             cts_on,
  output logic             iface_supply_en,
  output logic             iface_enable,
  output logic             ref_fast_sel,
  output logic             ref_slow_sel,
  output logic             cpu_run,
  output logic      [2:0]  mode_out
);

  localparam int NSYNC = 12;

  // Two-stage synchronisers; reset to rest levels so no false edge follows
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] prev_q;
  logic [NSYNC-1:0] pins;
  logic             sup_ok;
  assign pins = {supply_ok, busy, call_active, call_incoming, host_ready_indication,
                 usb_remote_wakeup, usb_bus_sense, rts_on, uart_rxd,
                 rtc_alarm, ext_reset_n, power_on_request_n};
  assign sup_ok = s2_q[11];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_q   <= `OMW_PIN_IDLE;
      s2_q   <= `OMW_PIN_IDLE;
      prev_q <= `OMW_PIN_IDLE;
    end
    else
    begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  function automatic logic rise(input logic [NSYNC-1:0] cur,
                                input logic [NSYNC-1:0] old, input int i);
    rise = cur[i] & ~old[i];
  endfunction

  logic pwr_fall;
  logic rst_rise;
  logic alarm_rise;
  logic rx_fall;
  logic wake_ev;
  logic call_start;
  logic call_end;
  logic rst_low;
  assign pwr_fall   = ~s2_q[0] & prev_q[0];
  assign rst_rise   = rise(s2_q, prev_q, 1);
  assign alarm_rise = rise(s2_q, prev_q, 2);
  // Idle-high line; a start bit is the first falling edge
  assign rx_fall    = ~s2_q[3] & prev_q[3];
  assign call_start = rise(s2_q, prev_q, 9);
  assign call_end   = ~s2_q[9] & prev_q[9];
  assign rst_low    = ~s2_q[1];

  // Registers
  logic [1:0] psv_q;
  logic [1:0] psv_d;
  logic       hwfc_q;
  logic       hwfc_d;
  logic       regd_q;
  logic       regd_d;
  logic       shut_req;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        wait_d;
  logic        wait_q;
  logic        acc;
  logic        wr_now;
  omw_mode_t   mode_q;
  omw_mode_t   mode_d;

  // Answer one cycle after the request; a write lands only on the answer edge
  assign acc    = (avs_read | avs_write) & wait_q;
  assign wr_now = avs_write & ~wait_q;

  always_comb
  begin
    psv_d    = psv_q;
    hwfc_d   = hwfc_q;
    regd_d   = regd_q;
    shut_req = 1'b0;
    wait_d   = ~acc;
    case (avs_address)
      `OMW_REG_CTRL:
      begin
        rdata_d = {28'h0, regd_q, hwfc_q, psv_q};
        if (wr_now)
        begin
          psv_d  = avs_writedata[`OMW_CTRL_PSV_LSB +: 2];
          hwfc_d = avs_writedata[`OMW_CTRL_HWFC_BIT];
          regd_d = avs_writedata[`OMW_CTRL_REG_BIT];
        end
      end
      `OMW_REG_STAT: rdata_d = {29'h0, mode_q};
      `OMW_REG_CMD:
      begin
        rdata_d = 32'h0;
        shut_req = wr_now & avs_writedata[`OMW_CMD_SHUT_BIT];
      end
      default: rdata_d = `OMW_BAD_ADDR_DATA;
    endcase
    if (mode_q == OMW_POWER_OFF || mode_q == OMW_NOT_POWERED)
      psv_d = 2'h0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      psv_q   <= 2'h0;
      hwfc_q  <= 1'b0;
      regd_q  <= 1'b0;
      rdata_q <= 32'h0;
      wait_q  <= 1'b1;
    end
    else
    begin
      psv_q   <= psv_d;
      hwfc_q  <= hwfc_d;
      regd_q  <= regd_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  // Mode machine with one counter for quiet time and periodic wake
  logic      [31:0] tmr_q;
  logic      [31:0] tmr_d;
  omw_mode_t        prior_q;
  omw_mode_t        prior_d;
  logic             wake_src;
  logic             quiet;

  assign wake_src = rise(s2_q, prev_q, 8) | alarm_rise | rx_fall | rise(s2_q, prev_q, 5)
                  | rise(s2_q, prev_q, 6) | rise(s2_q, prev_q, 7)
                  | ((psv_q == 2'h2) & s2_q[4]);
  assign quiet    = ~s2_q[10] & (psv_q != 2'h0);

  always_comb
  begin
    mode_d  = mode_q;
    tmr_d   = tmr_q;
    prior_d = prior_q;
    wake_ev = 1'b0;
    if (!sup_ok)
      mode_d = OMW_NOT_POWERED;
    else
    begin
      case (mode_q)
        OMW_NOT_POWERED: mode_d = OMW_POWER_OFF;
        OMW_POWER_OFF:
          if (pwr_fall | rst_rise | alarm_rise)
          begin
            mode_d = OMW_ACTIVE;
            tmr_d  = 32'h0;
          end
        OMW_ACTIVE:
        begin
          tmr_d = tmr_q + 32'h1;
          if (call_start)
          begin
            prior_d = OMW_ACTIVE;
            mode_d  = OMW_CONNECTED;
          end
          else if (!quiet || wake_src)
            tmr_d = 32'h0;
          else if (tmr_q >= 32'(HOLD_CYC))
          begin
            mode_d = OMW_IDLE;
            tmr_d  = 32'h0;
          end
        end
        OMW_IDLE:
        begin
          tmr_d   = tmr_q + 32'h1;
          wake_ev = wake_src;
          if (call_start)
          begin
            prior_d = OMW_IDLE;
            mode_d  = OMW_CONNECTED;
          end
          else if (wake_src || psv_q == 2'h0)
          begin
            mode_d = OMW_ACTIVE;
            tmr_d  = 32'h0;
          end
          else if (tmr_q >= 32'(POLL_CYC))
          begin
            mode_d = OMW_ACTIVE;
            tmr_d  = 32'(HOLD_CYC) - 32'(AWAKE_CYC);
          end
        end
        OMW_CONNECTED:
          if (call_end)
          begin
            mode_d = prior_q;
            tmr_d  = 32'h0;
          end
        default: mode_d = OMW_POWER_OFF;
      endcase
      if (shut_req)
        mode_d = OMW_POWER_OFF;
    end
  end

  logic cts_d;
  logic on_d;
  logic fast_d;
  always_comb
  begin
    on_d   = (mode_d == OMW_ACTIVE) | (mode_d == OMW_IDLE) | (mode_d == OMW_CONNECTED);
    fast_d = (mode_d == OMW_ACTIVE) | (mode_d == OMW_CONNECTED);
    cts_d  = hwfc_q ? fast_d : 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q          <= OMW_NOT_POWERED;
      prior_q         <= OMW_ACTIVE;
      tmr_q           <= 32'h0;
      cts_on          <= 1'b0;
      iface_supply_en <= 1'b0;
      iface_enable    <= 1'b0;
      ref_fast_sel    <= 1'b0;
      ref_slow_sel    <= 1'b0;
      cpu_run         <= 1'b0;
      mode_out        <= 3'h0;
    end
    else
    begin
      mode_q          <= mode_d;
      prior_q         <= prior_d;
      tmr_q           <= tmr_d;
      cts_on          <= cts_d;
      iface_supply_en <= on_d & ~rst_low;
      iface_enable    <= fast_d;
      ref_fast_sel    <= fast_d;
      ref_slow_sel    <= on_d & ~fast_d;
      cpu_run         <= on_d;
      mode_out        <= mode_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  property p_nopower;
    @(posedge clk) disable iff (!nrst) !sup_ok |=> mode_q == OMW_NOT_POWERED;
  endproperty
  a_nopower: assert property (p_nopower) else $error("switched on without supply");
  property p_poweron;
    @(posedge clk) disable iff (!nrst)
      (sup_ok && mode_q == OMW_POWER_OFF && pwr_fall && !shut_req) |=> mode_q == OMW_ACTIVE;
  endproperty
  a_poweron: assert property (p_poweron) else $error("power-on edge ignored");
  property p_shut;
    @(posedge clk) disable iff (!nrst) (sup_ok && shut_req) |=> mode_q == OMW_POWER_OFF;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown not taken");
  property p_idleref;
    @(posedge clk) disable iff (!nrst)
      mode_q == OMW_IDLE |-> ref_slow_sel && !ref_fast_sel && !iface_enable;
  endproperty
  a_idleref: assert property (p_idleref) else $error("idle reference wrong");
  property p_actref;
    @(posedge clk) disable iff (!nrst) mode_q == OMW_ACTIVE |-> ref_fast_sel && iface_enable;
  endproperty
  a_actref: assert property (p_actref) else $error("active reference wrong");
  property p_ctsoff;
    @(posedge clk) disable iff (!nrst) (!hwfc_q && $stable(hwfc_q) && $past(nrst)) |-> cts_on;
  endproperty
  a_ctsoff: assert property (p_ctsoff) else $error("cts not held on");
  property p_wake;
    @(posedge clk) disable iff (!nrst)
      (mode_q == OMW_IDLE && wake_ev && sup_ok && !shut_req && !call_start)
      |=> mode_q == OMW_ACTIVE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake source ignored");
  property p_callret;
    @(posedge clk) disable iff (!nrst)
      (mode_q == OMW_CONNECTED && call_end && sup_ok && !shut_req) |=> mode_q == $past(prior_q);
  endproperty
  a_callret: assert property (p_callret) else $error("wrong mode after call");
  property p_vint;
    @(posedge clk) disable iff (!nrst) ##1 rst_low |=> !iface_supply_en;
  endproperty
  a_vint: assert property (p_vint) else $error("supply out under reset");
endmodule

// ---- omw_consts.svh ----
// Timing counts and register layout for the operating-mode wake controller
// Included by the design only; definitions only
`ifndef OMW_CONSTS_SVH
`define OMW_CONSTS_SVH
`define OMW_CLK_HZ          25000000
`define OMW_IDLE_HOLD_US    100
`define OMW_IDLE_HOLD_CYC   ((`OMW_IDLE_HOLD_US * `OMW_CLK_HZ) / 1000000)
`define OMW_POLL_MS         500
`define OMW_POLL_CYC        ((`OMW_POLL_MS * (`OMW_CLK_HZ / 1000)))
`define OMW_AWAKE_US        1000
`define OMW_AWAKE_CYC       ((`OMW_AWAKE_US * `OMW_CLK_HZ) / 1000000)
`define OMW_REG_CTRL        4'h0
`define OMW_REG_STAT        4'h4
`define OMW_REG_CMD         4'h8
`define OMW_CTRL_PSV_LSB    0
`define OMW_CTRL_HWFC_BIT   2
`define OMW_CTRL_REG_BIT    3
`define OMW_CMD_SHUT_BIT    0
`define OMW_CTRL_RST        32'h0000_0000
`define OMW_BAD_ADDR_DATA   32'hdead_beef
// Synchroniser rest levels: power-on, reset and receive high, supply low
`define OMW_PIN_IDLE        12'h00b
`endif

// ---- omw_pkg.sv ----
// Types shared by the operating-mode wake controller
// Uses nothing from omw_consts.svh
package omw_pkg;
  typedef enum logic [2:0]
  {
    OMW_NOT_POWERED = 3'b000,
    OMW_POWER_OFF   = 3'b001,
    OMW_ACTIVE      = 3'b011,
    OMW_IDLE        = 3'b010,
    OMW_CONNECTED   = 3'b110
  } omw_mode_t;
endpackage

// ---- omw_host_model.sv ----
// Host processor model driving the wake and interface lines
// Assumes the bench commands each wake source by index on go
`timescale 1ns/1ps
module omw_host_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Command from the bench
  input  wire logic       go,
  input  wire logic [2:0] sel,
  // Lines into the device
  output logic            uart_rxd,
  output logic            rts_on,
  output logic            usb_bus_sense,
  output logic            usb_remote_wakeup,
  output logic            host_ready_indication,
  output logic            call_incoming
);
  logic [2:0] cnt_q;
  logic [2:0] sel_q;
  logic       on;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 3'h0;
      sel_q <= 3'h0;
    end
    else if (go)
    begin
      cnt_q <= 3'h6;
      sel_q <= sel;
    end
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
  assign on = (cnt_q != 3'h0);
  assign uart_rxd              = !(on && sel_q == 3'h0);
  assign usb_bus_sense         = on && sel_q == 3'h1;
  assign usb_remote_wakeup     = on && sel_q == 3'h2;
  assign host_ready_indication = on && sel_q == 3'h3;
  assign call_incoming         = on && sel_q == 3'h4;
  assign rts_on                = on && sel_q == 3'h5;
endmodule

// ---- operating_mode_wake_control_tb.sv ----
// Self-checking bench for the operating-mode wake controller
// Assumes omw_ctrl with shortened counts and the host model beside it
`timescale 1ns/1ps
`define CHK(n,e,s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module operating_mode_wake_control_tb;
  import omw_pkg::*;
  logic        clk, nrst, rd, wr, sup, pon_n, xrst_n, alarm, call, go, wt;
  logic        rxd, rts, vbus, rwk, hrdy, cin, busy;
  logic        cts_on, vint, ifen, fast, slow, cpu;
  logic [2:0]  sel, mode_out;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, e_v;
  logic [31:0] exp_q[$];
  int          error_cnt, checked;
  omw_ctrl #(.POLL_CYC(50), .AWAKE_CYC(5), .HOLD_CYC(10)) uut (.clk(clk), .nrst(nrst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .supply_ok(sup),
    .power_on_request_n(pon_n), .ext_reset_n(xrst_n), .rtc_alarm(alarm),
    .uart_rxd(rxd), .rts_on(rts), .usb_bus_sense(vbus), .usb_remote_wakeup(rwk),
    .host_ready_indication(hrdy), .call_incoming(cin), .call_active(call),
    .busy(busy), .cts_on(cts_on), .iface_supply_en(vint), .iface_enable(ifen),
    .ref_fast_sel(fast), .ref_slow_sel(slow), .cpu_run(cpu), .mode_out(mode_out));
  omw_host_model host (.clk(clk), .nrst(nrst), .go(go), .sel(sel), .uart_rxd(rxd),
    .rts_on(rts), .usb_bus_sense(vbus), .usb_remote_wakeup(rwk),
    .host_ready_indication(hrdy), .call_incoming(cin));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // Hold until the answer edge; the watchdog cuts a hang
    forever
    begin
      @(posedge clk);
      if (wt === 1'b0)
        break;
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rr(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task hold6;
    repeat (6) @(posedge clk);
  endtask
  task wmb(input logic [2:0] m, input int lim);
    for (int n = 0; n < lim && mode_out !== m; n++)
      @(posedge clk);
    rr(4'h4, {29'h0, m});
  endtask
  task kick(input logic [2:0] s);
    @(posedge clk);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Result checker: oldest note against each read answer
  always @(posedge clk)
  begin
    if (rd && wt === 1'b0)
    begin
      e_v = exp_q.pop_front();
      `CHK("readdata", e_v, rdat)
    end
  end
  initial
  begin
    #(40 * 30000);
    error_cnt++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(32'h5899429a));
    {nrst, rd, wr, sup, go, alarm, call, busy} = 8'h0;
    {pon_n, xrst_n} = 2'h3;
    sel = 3'h0;
    adr = 4'h0;
    wd = 32'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    pon_n <= 1'b0;
    alarm <= 1'b1;
    xrst_n <= 1'b0;
    hold6;
    {pon_n, alarm, xrst_n} <= 3'h5;
    repeat (10) @(posedge clk);
    `CHK("mode", 3'h0, mode_out)
    `CHK("vint", 1'b0, vint)
    sup <= 1'b1;
    wmb(3'h1, 200);
    pon_n <= 1'b0;
    hold6;
    pon_n <= 1'b1;
    wmb(3'h3, 20);
    `CHK("fast", 1'b1, fast)
    `CHK("ifen", 1'b1, ifen)
    `CHK("vint", 1'b1, vint)
    rr(4'h0, 32'h0);
    repeat (40) @(posedge clk);
    `CHK("mode", 3'h3, mode_out)
    busy <= 1'b1;
    bus(1'b1, 4'h0, 32'h5);
    repeat (30) @(posedge clk);
    `CHK("mode", 3'h3, mode_out)
    busy <= 1'b0;
    wmb(3'h2, 40);
    `CHK("slow", 1'b1, slow)
    `CHK("ifen", 1'b0, ifen)
    `CHK("cts", 1'b0, cts_on)
    wmb(3'h3, 80);
    `CHK("cts", 1'b1, cts_on)
    bus(1'b1, 4'h0, 32'hd);
    rr(4'h0, 32'hd);
    wmb(3'h2, 40);
    wmb(3'h3, 80);
    // Sources 0..4: uart, bus sense, remote wakeup, host ready, call
    for (int i = 0; i < 5; i++)
    begin
      wmb(3'h2, 40);
      repeat ($urandom_range(3, 0)) @(posedge clk);
      kick(i[2:0]);
      wmb(3'h3, 12);
    end
    wmb(3'h2, 40);
    alarm <= 1'b1;
    hold6;
    alarm <= 1'b0;
    wmb(3'h3, 8);
    bus(1'b1, 4'h0, 32'he);
    wmb(3'h2, 40);
    kick(3'h5);
    wmb(3'h3, 12);
    wmb(3'h2, 40);
    call <= 1'b1;
    wmb(3'h6, 12);
    call <= 1'b0;
    wmb(3'h2, 12);
    bus(1'b1, 4'h0, 32'h1);
    wmb(3'h2, 60);
    `CHK("cts", 1'b1, cts_on)
    xrst_n <= 1'b0;
    hold6;
    `CHK("vint", 1'b0, vint)
    xrst_n <= 1'b1;
    rr(4'hc, 32'hdeadbeef);
    bus(1'b1, 4'hc, $urandom);
    bus(1'b1, 4'h8, 32'h1);
    wmb(3'h1, 12);
    `CHK("ifen", 1'b0, ifen)
    `CHK("cpu", 1'b0, cpu)
    rr(4'h0, 32'h0);
    alarm <= 1'b1;
    hold6;
    alarm <= 1'b0;
    wmb(3'h3, 20);
    bus(1'b1, 4'h8, 32'h1);
    wmb(3'h1, 12);
    xrst_n <= 1'b0;
    hold6;
    xrst_n <= 1'b1;
    wmb(3'h3, 20);
    repeat (4) @(posedge clk);
    end_of_test;
  end
endmodule
